// ===== mup_meter_uart.sv
`timescale 1ns/1ps
// How it works
// RULE1: host byte gaps stay within 20 ms
// RULE2: read answer starts 150 us after address
// RULE3: response bytes go out back to back
// RULE4: read command plus 0xAA requests bulk packet
// RULE5: bulk packet is header plus 22 bytes
// RULE6: fixed packet layout, values LSB first
// RULE7: checksum is inverted sum incl. command, header
// RULE8: gap over 20 ms resets the interface
// RULE9: more than 32 zero bits resets interface
// RULE10: bad id or checksum discards whole frame; a bad id drops only its command byte, later bytes are checked as new commands
// RULE11: host waits timeout or resets between frames
// RULE12: characters are 8N1
// RULE13: command carries pattern plus strapped address
// RULE14: baud is 4800, 9600, 19200 or 38400
// RULE15: after reset or discard, next byte starts frame
module mup_meter_uart #(
  parameter int unsigned TIMEOUT_CYC = mup_pkg::TIMEOUT_CYC,
  parameter int unsigned RESP_CYC    = mup_pkg::RESP_CYC,
  parameter int unsigned DIV_4800    = mup_pkg::DIV_4800,
  parameter int unsigned DIV_9600    = mup_pkg::DIV_9600,
  parameter int unsigned DIV_19200   = mup_pkg::DIV_19200,
  parameter int unsigned DIV_38400   = mup_pkg::DIV_38400
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        uart_rx_pin,
  output logic             uart_tx_pin,
  input  wire logic        chip_addr_bit_high,
  input  wire logic        chip_addr_bit_low,
  input  wire logic        sclk_bps_pin,
  input  wire logic [1:0]  uart_rate_sel,
  input  wire logic [23:0] current_rms_value,
  input  wire logic [23:0] voltage_rms_value,
  input  wire logic [23:0] fast_current_rms_value,
  input  wire logic [23:0] active_power_value,
  input  wire logic [23:0] energy_pulse_count,
  input  wire logic [15:0] line_frequency_value,
  input  wire logic [7:0]  status_low_value,
  output logic [7:0]       reg_addr,
  input  wire logic [23:0] reg_rd_data,
  output logic             reg_wr_en,
  output logic [23:0]      reg_wr_data
);
  logic [1:0]  rx_sync_q, hi_sync_q, lo_sync_q, bps_sync_q;
  logic        rx_s;
  logic [15:0] div_q, div_d;
  logic        rx_valid, tx_ready, tx_valid, clr, timeout, zero_run;
  logic [7:0]  rx_data, tx_data;

  mup_pkg::mup_state_t state_q, state_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  cmd_q, cmd_d, addr_q, addr_d, sum_q, sum_d;
  logic [23:0] wdata_q, wdata_d;
  logic [31:0] gap_q, gap_d, wait_q, wait_d, zero_q, zero_d;
  logic [4:0]  idx_q, idx_d, last_idx;
  logic        pkt_mode_q, pkt_mode_d, wr_q, wr_d, cmd_ok;
  logic [7:0]  pkt_q [0:21];
  logic [7:0]  pkt_d [0:21];

  assign rx_s        = rx_sync_q[1];
  assign reg_addr    = addr_q;
  assign reg_wr_en   = wr_q;
  assign reg_wr_data = wdata_q;
  assign last_idx    = pkt_mode_q ? mup_pkg::PKT_LAST : mup_pkg::RD_LAST; // see RULE5
  assign cmd_ok      = rx_data[1:0] == {hi_sync_q[1], lo_sync_q[1]}; // see RULE13
  assign timeout     = gap_q >= TIMEOUT_CYC; // see RULE8
  assign zero_run    = zero_q > (32'(mup_pkg::ZERO_RUN_BITS) * {16'h0, div_q}); // see RULE9
  assign clr         = timeout || zero_run;
  assign tx_valid    = state_q == mup_pkg::MUP_SEND; // see RULE3
  assign tx_data     = (idx_q == last_idx) ? ~sum_q : pkt_q[idx_q]; // see RULE7

  always_comb begin
    unique case (uart_rate_sel) // see RULE14
      mup_pkg::RATE_19200: div_d = 16'(DIV_19200);
      mup_pkg::RATE_38400: div_d = 16'(DIV_38400);
      default:             div_d = bps_sync_q[1] ? 16'(DIV_9600) : 16'(DIV_4800);
    endcase
  end

  mup_uart_phy u_phy (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .clr      (clr),
    .bit_div  (div_q),
    .rx_in    (rx_s),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_ready (tx_ready),
    .tx_out   (uart_tx_pin)
  );

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    cmd_d      = cmd_q;
    addr_d     = addr_q;
    sum_d      = sum_q;
    wdata_d    = wdata_q;
    idx_d      = idx_q;
    pkt_mode_d = pkt_mode_q;
    wr_d       = 1'b0;
    pkt_d      = pkt_q;
    wait_d     = 32'h0;
    zero_d     = rx_s ? 32'h0 : zero_q + 32'h1;
    // the gap clock runs only inside a host frame
    gap_d      = (state_q == mup_pkg::MUP_ADDR || state_q == mup_pkg::MUP_WDATA) && !rx_valid ? gap_q + 32'h1 : 32'h0;
    unique case (state_q)
      mup_pkg::MUP_IDLE: begin
        if (rx_valid && cmd_ok && (rx_data[7:2] == mup_pkg::CMD_READ || rx_data[7:2] == mup_pkg::CMD_WRITE)) begin
          cmd_d   = rx_data;
          sum_d   = rx_data;
          state_d = mup_pkg::MUP_ADDR;
        end // others discarded, see RULE10
      end
      mup_pkg::MUP_ADDR: begin
        if (rx_valid) begin
          addr_d = rx_data;
          cnt_d  = 3'h0;
          if (cmd_q[7:2] == mup_pkg::CMD_WRITE) begin
            sum_d   = sum_q + rx_data;
            state_d = mup_pkg::MUP_WDATA;
          end else begin
            pkt_mode_d = rx_data == mup_pkg::BULK_ADDR; // see RULE4
            sum_d      = (rx_data == mup_pkg::BULK_ADDR) ? sum_q : sum_q + rx_data;
            state_d    = mup_pkg::MUP_WAIT;
          end
        end
      end
      mup_pkg::MUP_WDATA: begin
        if (rx_valid) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == mup_pkg::WR_LAST) begin
            wr_d    = rx_data == ~sum_q; // see RULE10
            state_d = mup_pkg::MUP_IDLE;
          end else begin
            wdata_d = {rx_data, wdata_q[23:8]};
            sum_d   = sum_q + rx_data;
          end
        end
      end
      mup_pkg::MUP_WAIT: begin
        wait_d = wait_q + 32'h1;
        if (wait_q == RESP_CYC - 1) begin // see RULE2
          // values are frozen here so a packet is one coherent snapshot
          idx_d = 5'h0;
          if (pkt_mode_q) begin // see RULE6
            pkt_d[0] = mup_pkg::PKT_HEADER;
            for (int i = 0; i < 3; i++) begin
              pkt_d[1 + i]  = current_rms_value[8*i +: 8];
              pkt_d[4 + i]  = voltage_rms_value[8*i +: 8];
              pkt_d[7 + i]  = fast_current_rms_value[8*i +: 8];
              pkt_d[10 + i] = active_power_value[8*i +: 8];
              pkt_d[13 + i] = energy_pulse_count[8*i +: 8];
            end
            pkt_d[16] = line_frequency_value[7:0];
            pkt_d[17] = line_frequency_value[15:8];
            pkt_d[18] = mup_pkg::PAD_BYTE;
            pkt_d[19] = status_low_value;
            pkt_d[20] = mup_pkg::PAD_BYTE;
            pkt_d[21] = mup_pkg::PAD_BYTE;
          end else begin
            pkt_d[0] = reg_rd_data[7:0];
            pkt_d[1] = reg_rd_data[15:8];
            pkt_d[2] = reg_rd_data[23:16];
          end
          state_d = mup_pkg::MUP_SEND;
        end
      end
      mup_pkg::MUP_SEND: begin
        if (tx_ready) begin
          idx_d = idx_q + 5'h1;
          sum_d = sum_q + tx_data; // see RULE7
          if (idx_q == last_idx) state_d = mup_pkg::MUP_IDLE;
        end
      end
      default: state_d = mup_pkg::MUP_IDLE;
    endcase
    if (clr) begin // see RULE15
      state_d = mup_pkg::MUP_IDLE;
      wr_d    = 1'b0;
      gap_d   = 32'h0;
      zero_d  = 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_sync_q  <= 2'h3;
      hi_sync_q  <= 2'h0;
      lo_sync_q  <= 2'h0;
      bps_sync_q <= 2'h0;
      div_q      <= 16'h0;
      state_q    <= mup_pkg::MUP_IDLE;
      cnt_q      <= 3'h0;
      cmd_q      <= 8'h0;
      addr_q     <= 8'h0;
      sum_q      <= 8'h0;
      wdata_q    <= 24'h0;
      gap_q      <= 32'h0;
      wait_q     <= 32'h0;
      zero_q     <= 32'h0;
      idx_q      <= 5'h0;
      pkt_mode_q <= 1'b0;
      wr_q       <= 1'b0;
      for (int i = 0; i < 22; i++) pkt_q[i] <= 8'h0;
    end else begin
      rx_sync_q  <= {rx_sync_q[0], uart_rx_pin};
      hi_sync_q  <= {hi_sync_q[0], chip_addr_bit_high};
      lo_sync_q  <= {lo_sync_q[0], chip_addr_bit_low};
      bps_sync_q <= {bps_sync_q[0], sclk_bps_pin};
      div_q      <= div_d;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      cmd_q      <= cmd_d;
      addr_q     <= addr_d;
      sum_q      <= sum_d;
      wdata_q    <= wdata_d;
      gap_q      <= gap_d;
      wait_q     <= wait_d;
      zero_q     <= zero_d;
      idx_q      <= idx_d;
      pkt_mode_q <= pkt_mode_d;
      wr_q       <= wr_d;
      pkt_q      <= pkt_d;
    end
  end

  sequence wait_enter_s;
    state_q == mup_pkg::MUP_ADDR && rx_valid && !clr && cmd_q[7:2] == mup_pkg::CMD_READ;
  endsequence
  sequence send_start_s;
    state_q == mup_pkg::MUP_SEND && idx_q == 5'h0;
  endsequence

  resp_delay_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE2
    (state_q == mup_pkg::MUP_WAIT && wait_q < RESP_CYC - 1) |=> state_q != mup_pkg::MUP_SEND)
    else $error("read answer started before the response delay");
  wait_exact_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE2
    (state_q == mup_pkg::MUP_WAIT && wait_q == RESP_CYC - 1 && !clr) |=> send_start_s)
    else $error("read answer did not start at the response delay");
  into_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE4
    wait_enter_s |=> (state_q == mup_pkg::MUP_WAIT && pkt_mode_q == $past(rx_data == mup_pkg::BULK_ADDR)))
    else $error("bulk selection wrong after read address");
  header_first_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE6
    (send_start_s and pkt_mode_q) |-> tx_data == mup_pkg::PKT_HEADER)
    else $error("bulk packet did not open with header");
  back_to_back_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE3
    (state_q == mup_pkg::MUP_SEND && tx_ready && idx_q != last_idx && !clr) |=> (!tx_ready && !uart_tx_pin))
    else $error("gap inside a response");
  pkt_length_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE5
    (state_q == mup_pkg::MUP_SEND && pkt_mode_q) |-> idx_q <= mup_pkg::PKT_LAST)
    else $error("bulk packet ran past its checksum");
  frame_timeout_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE8
    timeout |=> (state_q == mup_pkg::MUP_IDLE && gap_q == 32'h0))
    else $error("frame timeout did not reset the interface");
  zero_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE9
    zero_run |=> (state_q == mup_pkg::MUP_IDLE && !reg_wr_en))
    else $error("zero run did not reset the interface");
  bad_sum_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE10
    (state_q == mup_pkg::MUP_WDATA && cnt_q == mup_pkg::WR_LAST && rx_valid && rx_data != ~sum_q)
    |=> (!reg_wr_en && state_q == mup_pkg::MUP_IDLE))
    else $error("frame with bad checksum was acted on");
  bad_id_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE13
    (state_q == mup_pkg::MUP_IDLE && rx_valid && !cmd_ok) |=> state_q == mup_pkg::MUP_IDLE)
    else $error("foreign address accepted");
endmodule

// ===== mup_pkg.sv
package mup_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned BAUD_4800     = 4800;
  localparam int unsigned BAUD_9600     = 9600;
  localparam int unsigned BAUD_19200    = 19200;
  localparam int unsigned BAUD_38400    = 38400;
  // bit periods round down so the device never runs slow
  localparam int unsigned DIV_4800      = CLK_HZ / BAUD_4800;
  localparam int unsigned DIV_9600      = CLK_HZ / BAUD_9600;
  localparam int unsigned DIV_19200     = CLK_HZ / BAUD_19200;
  localparam int unsigned DIV_38400     = CLK_HZ / BAUD_38400;
  localparam int unsigned TIMEOUT_MS    = 20;
  localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned RESP_US       = 150;
  localparam int unsigned RESP_CYC      = RESP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ZERO_RUN_BITS = 32;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned FRAME_BITS    = 10;

  localparam logic [5:0] CMD_READ   = 6'h16;
  localparam logic [5:0] CMD_WRITE  = 6'h2a;
  localparam logic [7:0] BULK_ADDR  = 8'haa;
  localparam logic [7:0] PKT_HEADER = 8'h55;
  localparam logic [7:0] PAD_BYTE   = 8'h00;
  localparam logic [4:0] PKT_LAST   = 5'h16;
  localparam logic [4:0] RD_LAST    = 5'h03;
  localparam logic [2:0] WR_LAST    = 3'h3;
  localparam logic [1:0] RATE_19200 = 2'h2;
  localparam logic [1:0] RATE_38400 = 2'h3;

  typedef enum logic [2:0] {
    MUP_IDLE  = 3'h0,
    MUP_ADDR  = 3'h1,
    MUP_WDATA = 3'h2,
    MUP_WAIT  = 3'h3,
    MUP_SEND  = 3'h4
  } mup_state_t;

  typedef enum logic [1:0] {
    MUP_RX_IDLE  = 2'h0,
    MUP_RX_START = 2'h1,
    MUP_RX_DATA  = 2'h2,
    MUP_RX_STOP  = 2'h3
  } mup_rx_state_t;
endpackage

// ===== mup_uart_phy.sv
`timescale 1ns/1ps
module mup_uart_phy (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clr,
  input  wire logic [15:0] bit_div,
  input  wire logic        rx_in,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  output logic             tx_out
);
  mup_pkg::mup_rx_state_t rx_st_q, rx_st_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0]  rx_bit_q, rx_bit_d;
  logic [7:0]  rx_sh_q, rx_sh_d;
  logic        rx_prev_q, rx_vld_q, rx_vld_d;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0]  tx_bit_q, tx_bit_d;
  logic [9:0]  tx_sh_q, tx_sh_d;
  logic        tx_busy_q, tx_busy_d;

  assign rx_valid = rx_vld_q;
  assign rx_data  = rx_sh_q;
  assign tx_ready = !tx_busy_q;
  assign tx_out   = tx_sh_q[0];

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    rx_vld_d = 1'b0;
    if (rx_cnt_q != 16'h0) rx_cnt_d = rx_cnt_q - 16'h1;
    unique case (rx_st_q)
      mup_pkg::MUP_RX_IDLE: begin
        // a falling edge is needed, so a long zero run cannot restart a byte
        if (rx_prev_q && !rx_in) begin
          rx_st_d  = mup_pkg::MUP_RX_START;
          rx_cnt_d = {1'b0, bit_div[15:1]};
        end
      end
      mup_pkg::MUP_RX_START: begin
        if (rx_cnt_q == 16'h0) begin
          rx_st_d  = rx_in ? mup_pkg::MUP_RX_IDLE : mup_pkg::MUP_RX_DATA;
          // the zero-count cycle is part of the bit, so reload one short or the sample drifts late
          rx_cnt_d = bit_div - 16'h1;
          rx_bit_d = 4'h0;
        end
      end
      mup_pkg::MUP_RX_DATA: begin
        if (rx_cnt_q == 16'h0) begin
          rx_sh_d  = {rx_in, rx_sh_q[7:1]}; // see RULE12
          rx_bit_d = rx_bit_q + 4'h1;
          rx_cnt_d = bit_div - 16'h1;
          if (rx_bit_q == 4'(mup_pkg::DATA_BITS - 1)) rx_st_d = mup_pkg::MUP_RX_STOP;
        end
      end
      mup_pkg::MUP_RX_STOP: begin
        if (rx_cnt_q == 16'h0) begin
          rx_vld_d = rx_in; // see RULE12
          rx_st_d  = mup_pkg::MUP_RX_IDLE;
        end
      end
    endcase
    if (clr) begin
      rx_st_d  = mup_pkg::MUP_RX_IDLE;
      rx_vld_d = 1'b0;
    end
  end

  always_comb begin
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_sh_d   = tx_sh_q;
    tx_busy_d = tx_busy_q;
    if (!tx_busy_q) begin
      if (tx_valid) begin
        tx_sh_d   = {1'b1, tx_data, 1'b0}; // see RULE12
        tx_busy_d = 1'b1;
        tx_cnt_d  = bit_div - 16'h1;
        tx_bit_d  = 4'h0;
      end
    end else if (tx_cnt_q != 16'h0) begin
      tx_cnt_d = tx_cnt_q - 16'h1;
    end else begin
      tx_sh_d  = {1'b1, tx_sh_q[9:1]};
      tx_cnt_d = bit_div - 16'h1;
      tx_bit_d = tx_bit_q + 4'h1;
      if (tx_bit_q == 4'(mup_pkg::FRAME_BITS - 1)) tx_busy_d = 1'b0;
    end
    if (clr) begin
      tx_sh_d   = 10'h3ff;
      tx_busy_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_st_q   <= mup_pkg::MUP_RX_IDLE;
      rx_cnt_q  <= 16'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h0;
      rx_prev_q <= 1'b1;
      rx_vld_q  <= 1'b0;
      tx_cnt_q  <= 16'h0;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3ff;
      tx_busy_q <= 1'b0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bit_q  <= rx_bit_d;
      rx_sh_q   <= rx_sh_d;
      rx_prev_q <= rx_in;
      rx_vld_q  <= rx_vld_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_busy_q <= tx_busy_d;
    end
  end

  start_bit_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RULE12
    (!tx_busy_q && tx_valid && !clr) |=> (!tx_out && tx_busy_q))
    else $error("tx did not open with a start bit");
endmodule

// ===== mup_host_model.sv
`timescale 1ns/1ps
module mup_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] bit_div,
  output logic             host_tx,
  input  wire logic        dev_tx
);
  int unsigned cyc = 0;
  int unsigned last_end = 0;

  // host_tx has one writer, the bench process through these tasks
  task automatic line_idle();
    host_tx <= 1'b1;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end

  // bytes go out back to back, far inside the inter-byte limit
  // start, eight data bits lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_tx <= frame[i];
      repeat (bit_div) @(posedge ref_clk);
    end
    last_end = cyc;
  endtask

  // line held low to force the interface back to idle
  task automatic hold_low(input int unsigned n);
    host_tx <= 1'b0;
    repeat (n) @(posedge ref_clk);
    host_tx <= 1'b1;
    @(posedge ref_clk);
  endtask

  // got stays low when nothing starts within limit or the stop bit is low
  task automatic recv_byte(input int unsigned limit, output logic [7:0] b, output int unsigned t_start,
                           output logic got);
    int unsigned guard;
    guard = 0;
    got = 1'b0;
    b = 8'h00;
    t_start = 0;
    while (dev_tx !== 1'b0 && guard < limit) begin
      @(posedge ref_clk);
      guard++;
    end
    if (dev_tx === 1'b0) begin
      t_start = cyc;
      repeat (bit_div / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_div) @(posedge ref_clk);
        b[i] = dev_tx;
      end
      repeat (bit_div) @(posedge ref_clk);
      got = (dev_tx === 1'b1);
    end
  endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int unsigned T_CYC = 5000;
  localparam int unsigned R_CYC = 50;
  localparam logic [1:0]  RSEL [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  localparam logic        RPIN [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [15:0] RDIV [4] = '{16'h0010, 16'h000c, 16'h000a, 16'h0008};

  logic        ref_clk, reset_n, host_tx, dev_tx, chip_addr_bit_high, chip_addr_bit_low, sclk_bps_pin;
  logic [1:0]  uart_rate_sel;
  logic [15:0] bit_div, line_frequency_value;
  logic [23:0] current_rms_value, voltage_rms_value, fast_current_rms_value, active_power_value;
  logic [23:0] energy_pulse_count, reg_rd_data, reg_wr_data, wr_seen;
  logic [7:0]  status_low_value, reg_addr;
  logic        reg_wr_en;
  int unsigned miscompares = 0;
  int unsigned total_checks = 0;
  int unsigned wr_count = 0;

  mup_meter_uart #(.TIMEOUT_CYC(T_CYC), .RESP_CYC(R_CYC), .DIV_4800(16), .DIV_9600(12), .DIV_19200(10),
                   .DIV_38400(8)) u_mup_meter_uart (
    .ref_clk, .reset_n, .uart_rx_pin(host_tx), .uart_tx_pin(dev_tx), .chip_addr_bit_high,
    .chip_addr_bit_low, .sclk_bps_pin, .uart_rate_sel, .current_rms_value, .voltage_rms_value,
    .fast_current_rms_value, .active_power_value, .energy_pulse_count, .line_frequency_value,
    .status_low_value, .reg_addr, .reg_rd_data, .reg_wr_en, .reg_wr_data);

  mup_host_model u_mup_host_model (.ref_clk, .bit_div, .host_tx, .dev_tx);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (reg_wr_en === 1'b1) begin
      wr_count <= wr_count + 1;
      wr_seen <= reg_wr_data;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // out-of-range values are reported against the low bound
  task automatic check_range(input int unsigned seen, input int unsigned lo, input int unsigned hi);
    check((seen < lo || seen > hi) ? seen : lo, lo);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    u_mup_host_model.send_byte(b);
  endtask

  task automatic expect_silence();
    logic [7:0] b;
    int unsigned tp;
    logic got;
    u_mup_host_model.recv_byte(R_CYC + 200, b, tp, got);
    check(got, 1'b0);
  endtask

  // received bytes compared in order, each start after the first spaced one frame plus one idle cycle
  task automatic expect_bytes(input logic [7:0] exp [], input int unsigned gap_lo, input int unsigned gap_hi);
    logic [7:0] b;
    int unsigned tp, tprev;
    logic got;
    tprev = u_mup_host_model.last_end;
    for (int i = 0; i < exp.size(); i++) begin
      u_mup_host_model.recv_byte(R_CYC + 200, b, tp, got);
      check(got, 1'b1);
      check(b, exp[i]);
      if (i == 0) check_range(tp - tprev, gap_lo, gap_hi);
      else check_range(tp - tprev, 10 * bit_div, 10 * bit_div + 2);
      tprev = tp;
    end
    repeat (2 * bit_div) @(posedge ref_clk);
  endtask

  task automatic t_read(input logic [7:0] addr, input logic [23:0] d);
    logic [7:0] cmd;
    cmd = {mup_pkg::CMD_READ, chip_addr_bit_high, chip_addr_bit_low};
    reg_rd_data <= d;
    send(cmd);
    send(addr);
    expect_bytes('{d[7:0], d[15:8], d[23:16], ~(cmd + addr + d[7:0] + d[15:8] + d[23:16])}, R_CYC - 8, R_CYC + 8);
    check(reg_addr, addr);
  endtask

  task automatic t_write(input logic [7:0] addr, input logic [23:0] d, input logic bad);
    logic [7:0] cmd;
    int unsigned n;
    cmd = {mup_pkg::CMD_WRITE, chip_addr_bit_high, chip_addr_bit_low};
    n = wr_count;
    send(cmd);
    send(addr);
    send(d[7:0]);
    send(d[15:8]);
    send(d[23:16]);
    send(~(cmd + addr + d[7:0] + d[15:8] + d[23:16]) ^ {7'h00, bad});
    repeat (2 * bit_div) @(posedge ref_clk);
    check(wr_count - n, bad ? 0 : 1);
    if (!bad) begin
      check(wr_seen, d);
      check(reg_addr, addr);
    end
  endtask

  task automatic t_bulk();
    logic [7:0] cmd, sum;
    logic [7:0] exp [];
    cmd = {mup_pkg::CMD_READ, chip_addr_bit_high, chip_addr_bit_low};
    exp = '{8'h55, current_rms_value[7:0], current_rms_value[15:8], current_rms_value[23:16],
            voltage_rms_value[7:0], voltage_rms_value[15:8], voltage_rms_value[23:16],
            fast_current_rms_value[7:0], fast_current_rms_value[15:8], fast_current_rms_value[23:16],
            active_power_value[7:0], active_power_value[15:8], active_power_value[23:16],
            energy_pulse_count[7:0], energy_pulse_count[15:8], energy_pulse_count[23:16],
            line_frequency_value[7:0], line_frequency_value[15:8], 8'h00, status_low_value, 8'h00,
            8'h00, 8'h00};
    sum = cmd;
    for (int i = 0; i < 22; i++) sum += exp[i];
    exp[22] = ~sum;
    send(cmd);
    send(8'haa);
    expect_bytes(exp, R_CYC - 8, R_CYC + 8);
  endtask

  task automatic t_faults();
    logic [7:0] cmd;
    int unsigned n;
    cmd = {mup_pkg::CMD_WRITE, chip_addr_bit_high, chip_addr_bit_low};
    // another chip's id, then an address that is no id either
    send({mup_pkg::CMD_READ, ~chip_addr_bit_high, ~chip_addr_bit_low});
    send(8'h30);
    expect_silence();
    t_read(8'h41, 24'h0a0b0c);
    send({mup_pkg::CMD_READ, chip_addr_bit_high, chip_addr_bit_low});
    repeat (T_CYC + 100) @(posedge ref_clk);
    send(8'h12);
    expect_silence();
    // without the reset these bytes would complete a valid write
    send(cmd);
    send(8'h05);
    send(8'h11);
    u_mup_host_model.hold_low(33 * bit_div + 4);
    n = wr_count;
    send(8'h22);
    send(8'h33);
    send(~(cmd + 8'h05 + 8'h11 + 8'h22 + 8'h33));
    repeat (2 * bit_div) @(posedge ref_clk);
    check(wr_count - n, 0);
    t_read(8'h42, 24'hf0e1d2);
  endtask

  initial begin
    reset_n = 1'b0;
    u_mup_host_model.line_idle();
    chip_addr_bit_high = 1'b1;
    chip_addr_bit_low = 1'b0;
    sclk_bps_pin = 1'b0;
    uart_rate_sel = 2'h0;
    bit_div = 16'h0010;
    current_rms_value = 24'h123456;
    voltage_rms_value = 24'h9abcde;
    fast_current_rms_value = 24'h0f1e2d;
    active_power_value = 24'hc3b2a1;
    energy_pulse_count = 24'h654321;
    line_frequency_value = 16'h1388;
    status_low_value = 8'h5c;
    reg_rd_data = 24'h000000;
    wr_seen = 24'h000000;
    repeat (5) @(posedge ref_clk);
    check(dev_tx, 1'b1);
    check(reg_wr_en, 1'b0);
    reset_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      uart_rate_sel <= RSEL[r];
      sclk_bps_pin <= RPIN[r];
      bit_div <= RDIV[r];
      repeat (8) @(posedge ref_clk);
      t_read(8'h10 + 8'(r), 24'h5a0000 ^ {8'(r), 16'hc3a5});
    end
    t_write(8'h07, 24'h00ff81, 1'b0);
    t_write(8'h07, 24'h123456, 1'b1);
    t_bulk();
    t_faults();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
endmodule
